// ==== shared/ssdm_pkg.sv ====
// Constants and types for the servo status display monitor
package ssdm_pkg;

  // Operating modes of the front panel, cycled by the mode key
  typedef enum logic [1:0] {
    SSDM_MODE_STATUS = 2'h0,
    SSDM_MODE_PARAM  = 2'h1,
    SSDM_MODE_MONITOR = 2'h2,
    SSDM_MODE_UTILITY = 2'h3
  } ssdm_mode_t;

  // Sub-view inside parameter and monitor modes
  typedef enum logic [0:0] {
    SSDM_VIEW_NUMBER = 1'h0,
    SSDM_VIEW_VALUE  = 1'h1
  } ssdm_view_t;

  // Status code shown in the code field
  typedef enum logic [2:0] {
    SSDM_CODE_BASE_BLOCK = 3'h0,
    SSDM_CODE_RUN        = 3'h1,
    SSDM_CODE_FWD_PROHIB = 3'h2,
    SSDM_CODE_REV_PROHIB = 3'h3,
    SSDM_CODE_ALARM      = 3'h4
  } ssdm_code_t;

  // Data widths
  localparam int SSDM_DW = 16;
  localparam int SSDM_NUM_W = 8;

  // Threshold defaults
  localparam logic [15:0] SSDM_SPEED_POSITION_DONE_OUT_DEF = 16'h000a;  // 10 rpm
  localparam logic [15:0] SSDM_POS_DONE_DEF = 16'h000a;    // 10 pulse
  localparam logic [15:0] SSDM_ROT_DET_DEF = 16'h0014;     // 20 rpm
  localparam logic [15:0] SSDM_TORQUE_PCT = 16'h000a;      // 10 % of rated

  // Indicator bit positions
  localparam int SSDM_IND_POSITION_DONE_OUT = 0;
  localparam int SSDM_IND_BASE = 1;
  localparam int SSDM_IND_CPWR = 2;
  localparam int SSDM_IND_REF = 3;
  localparam int SSDM_IND_TRQ = 4;
  localparam int SSDM_IND_RDY = 5;
  localparam int SSDM_IND_ROT = 6;

  // Monitor item numbers
  localparam logic [7:0] SSDM_MON_SPEED = 8'h00;
  localparam logic [7:0] SSDM_MON_TORQUE = 8'h03;
  localparam logic [7:0] SSDM_MON_ANGLE = 8'h04;
  localparam logic [7:0] SSDM_MON_INPUTS = 8'h05;
  localparam logic [7:0] SSDM_MON_ENCODER = 8'h06;
  localparam logic [7:0] SSDM_MON_OUTPUTS = 8'h07;
  localparam logic [7:0] SSDM_MON_FREQ = 8'h08;
  localparam logic [7:0] SSDM_MON_ROT_CNT = 8'h09;
  localparam logic [7:0] SSDM_MON_ROT_SCL = 8'h0a;
  localparam logic [7:0] SSDM_MON_DEV_LO = 8'h0b;
  localparam logic [7:0] SSDM_MON_DEV_HI = 8'h0c;
  localparam logic [7:0] SSDM_MON_GIV_CNT = 8'h0d;
  localparam logic [7:0] SSDM_MON_GIV_SCL = 8'h0e;
  localparam logic [7:0] SSDM_MON_INERTIA = 8'h0f;
  localparam logic [7:0] SSDM_MON_OVERLOAD = 8'h10;
  localparam logic [7:0] SSDM_MON_BUS_V = 8'h11;
  localparam logic [7:0] SSDM_MON_LAST = 8'h11;

  // Encoder and output monitor bit positions
  localparam int SSDM_ENC_C = 4;
  localparam int SSDM_ENC_B = 5;
  localparam int SSDM_ENC_A = 6;
  localparam int SSDM_OUT_ALM = 0;
  localparam int SSDM_OUT_POSITION_DONE_OUT = 1;
  localparam int SSDM_OUT_ROT = 2;
  localparam int SSDM_OUT_RDY = 3;

  // Key hold auto-repeat timing
  localparam int SSDM_CLK_MHZ = 250;
  localparam int SSDM_HOLD_MS = 500;
  localparam int SSDM_REPEAT_MS = 50;
  localparam int SSDM_HOLD_CYC = SSDM_HOLD_MS * 1000 * SSDM_CLK_MHZ;
  localparam int SSDM_REPEAT_CYC = SSDM_REPEAT_MS * 1000 * SSDM_CLK_MHZ;
  localparam int SSDM_PARAM_LAST = 255;

  // Register map
  localparam logic [3:0] SSDM_REG_SPEED_THR = 4'h0;
  localparam logic [3:0] SSDM_REG_POS_THR = 4'h1;
  localparam logic [3:0] SSDM_REG_ROT_THR = 4'h2;
  localparam logic [3:0] SSDM_REG_STATUS = 4'h3;
  localparam logic [3:0] SSDM_REG_PANEL = 4'h4;
  localparam logic [3:0] SSDM_REG_PARAM_VAL = 4'h5;

endpackage

// ==== hdl/ssdm_key_repeat.sv ====
// Key press edge and hold auto-repeat generator
`timescale 1ns/1ns
module ssdm_key_repeat #(
  parameter int HOLD_CYC = 125000000,
  parameter int REPEAT_CYC = 12500000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Key level and stepped pulse
  input wire logic key,
  output logic step
);
  logic key_q;
  logic [31:0] cnt_q;
  logic repeating_q;

  // First press gives a step, holding repeats after a delay
  always_ff @(posedge clk) begin
    if (rst) begin
      key_q <= 1'b0;
      cnt_q <= 32'h0;
      repeating_q <= 1'b0;
      step <= 1'b0;
    end else if (ce) begin
      key_q <= key;
      step <= 1'b0;
      if (key && !key_q) begin
        step <= 1'b1;
        cnt_q <= 32'h0;
        repeating_q <= 1'b0;
      end else if (key) begin
        if (cnt_q >= 32'(repeating_q ? REPEAT_CYC - 1 : HOLD_CYC - 1)) begin
          step <= 1'b1;
          cnt_q <= 32'h0;
          repeating_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 32'h1;
        end
      end else begin
        repeating_q <= 1'b0;
      end
    end
  end
endmodule

// ==== hdl/ssdm_top.sv ====
// Servo status display and monitor logic for the front panel
//
// Functional notes
// - Status display mode selected after reset
// - Mode key cycles four modes with wrap
// - Indicator meanings depend on control mode
// - Speed coincidence when speed error within threshold
// - Torque control keeps coincidence lit
// - Position done when error below threshold
// - Base block lit unless servo on and motor power on
// - Control power indicator follows supply
// - Reference pulse lit in position only
// - Torque indicator above ten percent rated
// - Deviation clear indicator mirrors input
// - Power ready follows main supply
// - Rotation detected above rotation threshold
// - Code base block or run
// - Overtravel codes when inputs off
// - Alarm code shown, enter in status mode clears alarms
// - Parameter number and value key navigation
// - Monitor enter toggles number and value
// - Speed, torque, bus voltage monitor items
// - Deviation counter split low and high
// - Scaled and raw pulse count items
// - Input, encoder, output monitor bit maps
`timescale 1ns/1ns
module ssdm_top #(
  parameter int HOLD_CYC = ssdm_pkg::SSDM_HOLD_CYC,
  parameter int REPEAT_CYC = ssdm_pkg::SSDM_REPEAT_CYC
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Panel keys, levels
  input wire logic key_mode,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic key_enter,
  // Drive state
  input wire logic pos_ctrl,
  input wire logic torque_ctrl,
  input wire logic servo_on_in,
  input wire logic motor_power_on,
  input wire logic control_power_ok,
  input wire logic main_power_ok,
  input wire logic ref_pulse_active,
  input wire logic deviation_clear_in,
  input wire logic forward_overtravel_in,
  input wire logic reverse_overtravel_in,
  input wire logic proportional_control_in,
  input wire logic alarm_reset_in,
  input wire logic forward_current_limit_in,
  input wire logic reverse_current_limit_in,
  input wire logic alarm_active,
  input wire logic [7:0] alarm_number,
  input wire logic servo_ready,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_c,
  input wire logic signed [15:0] motor_speed,
  input wire logic signed [15:0] ref_speed,
  input wire logic signed [15:0] torque_ref_pct,
  input wire logic signed [31:0] pos_error,
  input wire logic [15:0] angle_pulses,
  input wire logic [15:0] pulse_freq_khz,
  input wire logic [31:0] rotation_pulses,
  input wire logic [31:0] given_pulses,
  input wire logic [15:0] inertia_pct,
  input wire logic [15:0] overload_pct,
  input wire logic [15:0] bus_voltage,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Display outputs
  output ssdm_pkg::ssdm_mode_t mode,
  output ssdm_pkg::ssdm_view_t view,
  output logic [6:0] indicators,
  output ssdm_pkg::ssdm_code_t status_code,
  output logic [7:0] alarm_code,
  output logic [7:0] item_number,
  output logic [15:0] item_value,
  output logic alarm_clear,
  output logic rotation_detected_out,
  output logic position_done_out,
  output logic alarm_out
);
  import ssdm_pkg::*;

  logic [15:0] speed_thr_q;
  logic [15:0] pos_thr_q;
  logic [15:0] rot_thr_q;
  logic [7:0] param_num_q;
  logic [7:0] mon_num_q;
  logic [15:0] param_mem [0:255];
  logic step_mode;
  logic step_up;
  logic step_down;
  logic step_enter;
  logic [6:0] ind_d;
  logic [15:0] speed_err;
  logic [15:0] speed_abs;
  logic [31:0] pos_abs;
  logic position_done_out_d;
  logic rot_d;
  ssdm_code_t code_d;
  logic [15:0] mon_d;

  // Absolute value helper
  function automatic logic [15:0] abs16(input logic signed [15:0] v);
    abs16 = v[15] ? 16'(-v) : 16'(v);
  endfunction

  // Item stepping with wrap
  function automatic logic [7:0] step_num(input logic [7:0] n, input logic up,
                                          input logic [7:0] last);
    if (up) step_num = (n == last) ? 8'h00 : 8'(n + 8'h01);
    else step_num = (n == 8'h00) ? last : 8'(n - 8'h01);
  endfunction

  // Key edge and repeat generators, one per key
  ssdm_key_repeat #(.HOLD_CYC(HOLD_CYC), .REPEAT_CYC(REPEAT_CYC)) u_mode (
    .clk(clk), .rst(rst), .ce(ce), .key(key_mode), .step(step_mode));
  ssdm_key_repeat #(.HOLD_CYC(HOLD_CYC), .REPEAT_CYC(REPEAT_CYC)) u_up (
    .clk(clk), .rst(rst), .ce(ce), .key(key_up), .step(step_up));
  ssdm_key_repeat #(.HOLD_CYC(HOLD_CYC), .REPEAT_CYC(REPEAT_CYC)) u_down (
    .clk(clk), .rst(rst), .ce(ce), .key(key_down), .step(step_down));
  ssdm_key_repeat #(.HOLD_CYC(HOLD_CYC), .REPEAT_CYC(REPEAT_CYC)) u_enter (
    .clk(clk), .rst(rst), .ce(ce), .key(key_enter), .step(step_enter));

  // Indicator and code decode from live drive state
  always_comb begin
    speed_err = 16'(motor_speed - ref_speed);
    speed_abs = abs16(speed_err);
    pos_abs = pos_error[31] ? 32'(-pos_error) : 32'(pos_error);
    position_done_out_d = torque_ctrl ? 1'b1 : (speed_abs <= speed_thr_q);
    rot_d = abs16(motor_speed) > rot_thr_q;
    ind_d = 7'h0;
    if (pos_ctrl) begin
      ind_d[SSDM_IND_POSITION_DONE_OUT] = pos_abs < 32'(pos_thr_q);
      ind_d[SSDM_IND_REF] = ref_pulse_active;
      ind_d[SSDM_IND_TRQ] = deviation_clear_in;
    end else begin
      ind_d[SSDM_IND_POSITION_DONE_OUT] = position_done_out_d;
      ind_d[SSDM_IND_REF] = 1'b0;
      ind_d[SSDM_IND_TRQ] = !torque_ref_pct[15] &&
                            (16'(torque_ref_pct) > SSDM_TORQUE_PCT);
    end
    ind_d[SSDM_IND_BASE] = !(servo_on_in && motor_power_on);
    ind_d[SSDM_IND_CPWR] = control_power_ok;
    ind_d[SSDM_IND_RDY] = main_power_ok;
    ind_d[SSDM_IND_ROT] = rot_d;
    // Alarm outranks overtravel, which outranks run state
    if (alarm_active) code_d = SSDM_CODE_ALARM;
    else if (!forward_overtravel_in) code_d = SSDM_CODE_FWD_PROHIB;
    else if (!reverse_overtravel_in) code_d = SSDM_CODE_REV_PROHIB;
    else if (servo_on_in && motor_power_on) code_d = SSDM_CODE_RUN;
    else code_d = SSDM_CODE_BASE_BLOCK;
  end

  // Monitor item selection
  always_comb begin
    case (mon_num_q)
      SSDM_MON_SPEED: mon_d = 16'(motor_speed);
      SSDM_MON_TORQUE: mon_d = 16'(torque_ref_pct);
      SSDM_MON_ANGLE: mon_d = angle_pulses;
      SSDM_MON_INPUTS: mon_d = {8'h00, reverse_current_limit_in,
                                forward_current_limit_in, deviation_clear_in,
                                alarm_reset_in, reverse_overtravel_in,
                                forward_overtravel_in, proportional_control_in,
                                servo_on_in};
      SSDM_MON_ENCODER: mon_d = 16'({13'h0, enc_a, enc_b, enc_c} << SSDM_ENC_C);
      SSDM_MON_OUTPUTS: mon_d = {12'h000, servo_ready, rot_d,
                                 (pos_ctrl ? ind_d[SSDM_IND_POSITION_DONE_OUT] : position_done_out_d),
                                 alarm_active};
      SSDM_MON_FREQ: mon_d = pulse_freq_khz;
      SSDM_MON_ROT_CNT: mon_d = rotation_pulses[15:0];
      SSDM_MON_ROT_SCL: mon_d = 16'(rotation_pulses / 32'd10000);
      SSDM_MON_DEV_LO: mon_d = pos_error[15:0];
      SSDM_MON_DEV_HI: mon_d = pos_error[31:16];
      SSDM_MON_GIV_CNT: mon_d = given_pulses[15:0];
      SSDM_MON_GIV_SCL: mon_d = 16'(given_pulses / 32'd10000);
      SSDM_MON_INERTIA: mon_d = inertia_pct;
      SSDM_MON_OVERLOAD: mon_d = overload_pct;
      SSDM_MON_BUS_V: mon_d = bus_voltage;
      default: mon_d = 16'h0000;
    endcase
  end

  // Live indicators and status, registered on every cycle with ce high
  always_ff @(posedge clk) begin
    if (rst) begin
      indicators <= 7'h0;
      status_code <= SSDM_CODE_BASE_BLOCK;
      alarm_code <= 8'h00;
      rotation_detected_out <= 1'b0;
      position_done_out <= 1'b0;
      alarm_out <= 1'b0;
    end else if (ce) begin
      indicators <= ind_d;
      status_code <= code_d;
      alarm_code <= alarm_active ? alarm_number : 8'h00;
      rotation_detected_out <= rot_d;
      position_done_out <= ind_d[SSDM_IND_POSITION_DONE_OUT];
      alarm_out <= alarm_active;
    end
  end

  // Mode and view navigation
  always_ff @(posedge clk) begin
    if (rst) begin
      mode <= SSDM_MODE_STATUS;
      view <= SSDM_VIEW_NUMBER;
      alarm_clear <= 1'b0;
    end else if (ce) begin
      alarm_clear <= 1'b0;
      if (step_mode) begin
        if (mode == SSDM_MODE_PARAM && view == SSDM_VIEW_VALUE) begin
          view <= SSDM_VIEW_NUMBER;
        end else begin
          view <= SSDM_VIEW_NUMBER;
          case (mode)
            SSDM_MODE_STATUS: mode <= SSDM_MODE_PARAM;
            SSDM_MODE_PARAM: mode <= SSDM_MODE_MONITOR;
            SSDM_MODE_MONITOR: mode <= SSDM_MODE_UTILITY;
            SSDM_MODE_UTILITY: mode <= SSDM_MODE_STATUS;
            default: mode <= SSDM_MODE_STATUS;
          endcase
        end
      end else if (step_enter) begin
        case (mode)
          SSDM_MODE_STATUS: alarm_clear <= alarm_active;
          SSDM_MODE_PARAM, SSDM_MODE_MONITOR: view <= ssdm_view_t'(~view);
          default: view <= SSDM_VIEW_NUMBER;
        endcase
      end
    end
  end

  // Parameter and monitor number selection, in number view only
  always_ff @(posedge clk) begin
    if (rst) begin
      param_num_q <= 8'h00;
      mon_num_q <= SSDM_MON_SPEED;
    end else if (ce && (step_up ^ step_down) && view == SSDM_VIEW_NUMBER) begin
      if (mode == SSDM_MODE_PARAM)
        param_num_q <= step_num(param_num_q, step_up, 8'(SSDM_PARAM_LAST));
      else if (mode == SSDM_MODE_MONITOR)
        mon_num_q <= step_num(mon_num_q, step_up, SSDM_MON_LAST);
    end
  end

  // Parameter value store, edited by keys or written by software
  always_ff @(posedge clk) begin
    if (ce) begin
      if (mode == SSDM_MODE_PARAM && view == SSDM_VIEW_VALUE && (step_up ^ step_down))
        param_mem[param_num_q] <= step_up ? param_mem[param_num_q] + 16'h1 :
                                            param_mem[param_num_q] - 16'h1;
      else if (reg_wr && reg_addr == SSDM_REG_PARAM_VAL)
        param_mem[param_num_q] <= reg_wdata;
    end
  end

  // Displayed item number and value
  always_ff @(posedge clk) begin
    if (rst) begin
      item_number <= 8'h00;
      item_value <= 16'h0000;
    end else if (ce) begin
      item_number <= (mode == SSDM_MODE_MONITOR) ? mon_num_q : param_num_q;
      if (mode == SSDM_MODE_MONITOR) item_value <= mon_d;
      else item_value <= param_mem[param_num_q];
    end
  end

  // Threshold registers
  always_ff @(posedge clk) begin
    if (rst) begin
      speed_thr_q <= SSDM_SPEED_POSITION_DONE_OUT_DEF;
      pos_thr_q <= SSDM_POS_DONE_DEF;
      rot_thr_q <= SSDM_ROT_DET_DEF;
    end else if (ce && reg_wr) begin
      if (reg_addr == SSDM_REG_SPEED_THR) speed_thr_q <= reg_wdata;
      if (reg_addr == SSDM_REG_POS_THR) pos_thr_q <= reg_wdata;
      if (reg_addr == SSDM_REG_ROT_THR) rot_thr_q <= reg_wdata;
    end
  end

  // Register read port, data one cycle after strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      if (reg_rd) begin
        case (reg_addr)
          SSDM_REG_SPEED_THR: reg_rdata <= speed_thr_q;
          SSDM_REG_POS_THR: reg_rdata <= pos_thr_q;
          SSDM_REG_ROT_THR: reg_rdata <= rot_thr_q;
          SSDM_REG_STATUS: reg_rdata <= {6'h00, status_code, indicators};
          SSDM_REG_PANEL: reg_rdata <= {5'h00, view, mode, item_number};
          SSDM_REG_PARAM_VAL: reg_rdata <= param_mem[param_num_q];
          default: reg_rdata <= 16'h0000;
        endcase
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  // Checks
  property p_base_block;
    @(posedge clk) disable iff (rst)
      ce && !(servo_on_in && motor_power_on) |=> indicators[SSDM_IND_BASE];
  endproperty
  a_base_block: assert property (p_base_block) else $error("base block dark");

  property p_torque_position_done_out;
    @(posedge clk) disable iff (rst)
      ce && torque_ctrl && !pos_ctrl |=> indicators[SSDM_IND_POSITION_DONE_OUT];
  endproperty
  a_torque_position_done_out: assert property (p_torque_position_done_out) else $error("coincidence dark");

  property p_ref_dark;
    @(posedge clk) disable iff (rst)
      ce && !pos_ctrl |=> !indicators[SSDM_IND_REF];
  endproperty
  a_ref_dark: assert property (p_ref_dark) else $error("reference lit");

  property p_alarm_code;
    @(posedge clk) disable iff (rst)
      ce && alarm_active |=> status_code == SSDM_CODE_ALARM && alarm_code == $past(alarm_number);
  endproperty
  a_alarm_code: assert property (p_alarm_code) else $error("alarm code wrong");

  property p_mode_cycle;
    @(posedge clk) disable iff (rst)
      ce && step_mode && mode == SSDM_MODE_UTILITY |=> mode == SSDM_MODE_STATUS;
  endproperty
  a_mode_cycle: assert property (p_mode_cycle) else $error("mode no wrap");

  property p_cpwr;
    @(posedge clk) disable iff (rst)
      ce |=> indicators[SSDM_IND_CPWR] == $past(control_power_ok);
  endproperty
  a_cpwr: assert property (p_cpwr) else $error("control power wrong");

  property p_fwd_ot;
    @(posedge clk) disable iff (rst)
      ce && !alarm_active && !forward_overtravel_in |=> status_code == SSDM_CODE_FWD_PROHIB;
  endproperty
  a_fwd_ot: assert property (p_fwd_ot) else $error("overtravel code");

  property p_mon_enter;
    @(posedge clk) disable iff (rst)
      ce && !step_mode && step_enter && mode == SSDM_MODE_MONITOR |=> view != $past(view);
  endproperty
  a_mon_enter: assert property (p_mon_enter) else $error("monitor view");
endmodule

// ==== verification/ssdm_panel_model.sv ====
// Keypad model for the front panel: presses one key at a time
`timescale 1ns/1ns
module ssdm_panel_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // One-hot request: mode, up, down, enter
  input wire logic [3:0] req,
  // Key levels, high while pressed
  output logic [3:0] keys
);
  logic [1:0] hold_q;
  logic [3:0] key_q;
  // Hold the key two cycles, short of the repeat delay
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_q <= 2'h0;
      key_q <= 4'h0;
    end else if (req != 4'h0) begin
      hold_q <= 2'h2;
      key_q <= req;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end
  end
  // Released keys read as not pressed
  assign keys = (hold_q != 2'h0) ? key_q : 4'h0;
endmodule

// ==== verification/tb.sv ====
// Bench for the servo status display monitor
`timescale 1ns/1ns
module tb;
  import ssdm_pkg::*;
  logic clk = 0, rst = 1, ce = 1, pos_ctrl = 0, torque_ctrl = 0;
  logic servo_on_in = 0, motor_power_on = 0, control_power_ok = 0, main_power_ok = 0;
  logic ref_pulse_active = 0, deviation_clear_in = 0, forward_overtravel_in = 1;
  logic reverse_overtravel_in = 1, proportional_control_in = 0, alarm_reset_in = 0;
  logic forward_current_limit_in = 0, reverse_current_limit_in = 0, alarm_active = 0;
  logic servo_ready = 0, enc_a = 0, enc_b = 0, enc_c = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0] alarm_number = 8'h00;
  logic signed [15:0] motor_speed = 16'h0000, ref_speed = 16'h0000;
  logic signed [15:0] torque_ref_pct = 16'h0000;
  logic signed [31:0] pos_error = 32'h0000_0000;
  logic [15:0] angle_pulses = 16'h0000, pulse_freq_khz = 16'h0000, inertia_pct = 16'h0000;
  logic [15:0] overload_pct = 16'h0000, bus_voltage = 16'h0000, reg_wdata = 16'h0000;
  logic [31:0] rotation_pulses = 32'h0000_0000, given_pulses = 32'h0000_0000;
  logic [3:0] reg_addr = 4'h0, req = 4'h0, keys;
  logic [15:0] reg_rdata, item_value, d;
  logic [7:0] alarm_code, item_number, cur;
  logic [6:0] indicators;
  ssdm_mode_t mode;
  ssdm_view_t view;
  ssdm_code_t status_code;
  logic alarm_clear, rotation_detected_out, position_done_out, alarm_out;
  int n_fail = 0, total_checks = 0, n_clr = 0;
  // 250 MHz clock
  initial forever #2 clk = ~clk;
  ssdm_top #(.HOLD_CYC(8), .REPEAT_CYC(4)) DUT (
    .clk, .rst, .ce, .key_mode(keys[0]), .key_up(keys[1]), .key_down(keys[2]),
    .key_enter(keys[3]), .pos_ctrl, .torque_ctrl, .servo_on_in, .motor_power_on,
    .control_power_ok, .main_power_ok, .ref_pulse_active, .deviation_clear_in,
    .forward_overtravel_in, .reverse_overtravel_in, .proportional_control_in,
    .alarm_reset_in, .forward_current_limit_in, .reverse_current_limit_in,
    .alarm_active, .alarm_number, .servo_ready, .enc_a, .enc_b, .enc_c, .motor_speed,
    .ref_speed, .torque_ref_pct, .pos_error, .angle_pulses, .pulse_freq_khz,
    .rotation_pulses, .given_pulses, .inertia_pct, .overload_pct, .bus_voltage,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mode, .view, .indicators,
    .status_code, .alarm_code, .item_number, .item_value, .alarm_clear,
    .rotation_detected_out, .position_done_out, .alarm_out);
  ssdm_panel_model MODEL (.clk, .rst, .req, .keys);
  // Counts one-cycle clear pulses
  always @(posedge clk) if (alarm_clear === 1'b1) n_clr++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Keeps the request up for n edges, long holds reach auto-repeat
  task automatic hold(input logic [3:0] k, input int n);
    @(posedge clk);
    req <= k;
    repeat (n) @(posedge clk);
    req <= 4'h0;
    tick(5);
  endtask
  task automatic press(input logic [3:0] k);
    hold(k, 1);
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Steps up to an item, opens its value, then returns
  task automatic mon(input logic [7:0] n, input logic [15:0] v);
    for (int i = 0; i < 18 && cur != n; i++) begin
      press(4'h2);
      cur = (cur == 8'h11) ? 8'h00 : cur + 8'h01;
    end
    chk(item_number, n);
    press(4'h8);
    chk(view, SSDM_VIEW_VALUE);
    chk(item_value, v);
    press(4'h8);
    chk(view, SSDM_VIEW_NUMBER);
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    chk(mode, SSDM_MODE_STATUS);
    chk(status_code, SSDM_CODE_BASE_BLOCK);
    rd(SSDM_REG_SPEED_THR);
    chk(d, SSDM_SPEED_POSITION_DONE_OUT_DEF);
    rd(SSDM_REG_POS_THR);
    chk(d, SSDM_POS_DONE_DEF);
    rd(SSDM_REG_ROT_THR);
    chk(d, SSDM_ROT_DET_DEF);
    rd(4'hf);
    chk(d, 16'h0000);
    @(posedge clk);
    control_power_ok <= 1'b1;
    main_power_ok <= 1'b1;
    motor_speed <= 16'h001e;
    ref_speed <= 16'h0014;
    torque_ref_pct <= 16'h000b;
    ref_pulse_active <= 1'b1;
    tick(3);
    chk(indicators, 7'h77);
    chk(rotation_detected_out, 1'b1);
    chk(position_done_out, 1'b1);
    @(posedge clk);
    main_power_ok <= 1'b0;
    motor_speed <= 16'h0014;
    ref_speed <= 16'h0009;
    torque_ref_pct <= 16'h000a;
    tick(3);
    chk(indicators, 7'h06);
    @(posedge clk);
    torque_ctrl <= 1'b1;
    tick(3);
    chk(indicators, 7'h07);
    @(posedge clk);
    torque_ctrl <= 1'b0;
    pos_ctrl <= 1'b1;
    pos_error <= 32'h0000_0009;
    deviation_clear_in <= 1'b1;
    tick(3);
    chk(indicators, 7'h1f);
    @(posedge clk);
    pos_error <= 32'h0000_000a;
    deviation_clear_in <= 1'b0;
    ref_pulse_active <= 1'b0;
    servo_on_in <= 1'b1;
    motor_power_on <= 1'b1;
    tick(3);
    chk(indicators, 7'h04);
    chk(status_code, SSDM_CODE_RUN);
    wr(SSDM_REG_POS_THR, 16'h000b);
    tick(3);
    chk(indicators, 7'h05);
    chk(position_done_out, 1'b1);
    @(posedge clk);
    ce <= 1'b0;
    control_power_ok <= 1'b0;
    tick(3);
    chk(indicators, 7'h05);
    @(posedge clk);
    ce <= 1'b1;
    tick(3);
    chk(indicators, 7'h01);
    @(posedge clk);
    control_power_ok <= 1'b1;
    forward_overtravel_in <= 1'b0;
    tick(3);
    chk(status_code, SSDM_CODE_FWD_PROHIB);
    @(posedge clk);
    forward_overtravel_in <= 1'b1;
    reverse_overtravel_in <= 1'b0;
    tick(3);
    chk(status_code, SSDM_CODE_REV_PROHIB);
    @(posedge clk);
    reverse_overtravel_in <= 1'b1;
    alarm_active <= 1'b1;
    alarm_number <= 8'h2a;
    tick(3);
    chk(status_code, SSDM_CODE_ALARM);
    chk(alarm_code, 8'h2a);
    chk(alarm_out, 1'b1);
    press(4'h8);
    chk(n_clr, 1);
    @(posedge clk);
    alarm_active <= 1'b0;
    press(4'h1);
    chk(mode, SSDM_MODE_PARAM);
    chk(alarm_out, 1'b0);
    press(4'h2);
    press(4'h2);
    chk(item_number, 8'h02);
    hold(4'h2, 12);
    chk(item_number, 8'h05);
    wr(SSDM_REG_PARAM_VAL, 16'h0064);
    press(4'h8);
    chk(view, SSDM_VIEW_VALUE);
    chk(item_value, 16'h0064);
    press(4'h4);
    chk(item_value, 16'h0063);
    rd(SSDM_REG_PARAM_VAL);
    chk(d, 16'h0063);
    press(4'h1);
    chk(view, SSDM_VIEW_NUMBER);
    chk(mode, SSDM_MODE_PARAM);
    @(posedge clk);
    motor_speed <= 16'h0100;
    torque_ref_pct <= 16'h0032;
    bus_voltage <= 16'h0136;
    pos_error <= 32'h0012_3456;
    rotation_pulses <= 32'h0001_e240;
    given_pulses <= 32'h0003_d090;
    deviation_clear_in <= 1'b1;
    reverse_current_limit_in <= 1'b1;
    enc_a <= 1'b1;
    enc_c <= 1'b1;
    servo_ready <= 1'b1;
    press(4'h1);
    chk(mode, SSDM_MODE_MONITOR);
    chk(item_number, 8'h00);
    press(4'h4);
    cur = 8'h11;
    mon(8'h11, 16'h0136);
    mon(8'h00, 16'h0100);
    mon(8'h03, 16'h0032);
    mon(8'h05, 16'h00ad);
    mon(8'h06, 16'h0050);
    mon(8'h07, 16'h000c);
    mon(8'h0a, 16'h000c);
    mon(8'h0b, 16'h3456);
    mon(8'h0c, 16'h0012);
    mon(8'h0e, 16'h0019);
    press(4'h1);
    chk(mode, SSDM_MODE_UTILITY);
    press(4'h1);
    chk(mode, SSDM_MODE_STATUS);
    finish_test();
  end
endmodule
